// file: src/ptp_pkg.sv
/*
 Shared constants and types for the timing-message detect, time clock and
 target compare block. Assumes a 100 MHz system clock and an AHB-Lite host.
*/
package ptp_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CFG      = 8'h00;
   localparam logic [7:0] OFS_CMD      = 8'h04;
   localparam logic [7:0] OFS_FLAGS    = 8'h08;
   localparam logic [7:0] OFS_SYS      = 8'h0c;
   localparam logic [7:0] OFS_ADDEND   = 8'h18;
   localparam logic [7:0] OFS_XADDR_HI = 8'h2c;
   localparam logic [7:0] OFS_XADDR_LO = 8'h30;
   localparam logic [7:0] OFS_CAP_BASE = 8'h40;
   // Split 64-bit pairs: 0 time, 1 match time, 2 next match
   localparam logic [7:0] OFS_PAIR_HI [3] = '{8'h10, 8'h1c, 8'h24};
   localparam logic [7:0] OFS_PAIR_LO [3] = '{8'h14, 8'h20, 8'h28};
   // ==========================================================
   // Field positions
   localparam int CFG_MODE_LSB   = 0;
   localparam int CFG_RELOAD_BIT = 3;
   localparam int CFG_EN_LSB     = 4;
   localparam int CFG_GCLR_LSB   = 19;
   localparam int CFG_W          = 21;
   localparam int CMD_SNAP_BIT   = 0;
   localparam int FL_GPIO_LSB    = 6;
   localparam int FL_TIMER       = 8;
   localparam int FL_W           = 9;
   localparam int IE_LSB         = 16;
   localparam logic [31:0] RST_ADDEND = 32'h0;
   // ==========================================================
   // Frame layout
   localparam logic [6:0]  PAY_UNTAG   = 7'd42;
   localparam logic [6:0]  PAY_TAG     = 7'd46;
   localparam logic [6:0]  CTL_OFS     = 7'd32;
   localparam logic [6:0]  TYPE_OFS    = 7'd13;
   localparam logic [6:0]  VLAN_LEN    = 7'd4;
   localparam logic [15:0] VLAN_TYPE   = 16'h8100;
   localparam logic [15:0] IPV4_TYPE   = 16'h0800;
   localparam logic [47:0] ADDR_FIX0   = 48'h01005e000181;
   localparam logic [7:0]  MSG_SYNC    = 8'h00;
   localparam logic [7:0]  MSG_DREQ    = 8'h01;
   // ==========================================================
   // Timing
   localparam int CLK_NS       = 10;
   localparam int GPIO_MIN_NS  = 40;
   localparam int GPIO_MIN_CYC = (GPIO_MIN_NS + CLK_NS - 1) / CLK_NS;

   // One byte of a frame path; sof marks byte 0, eof the last byte
   typedef struct packed {
      logic       vld;
      logic       sof;
      logic       eof;
      logic       fcs_ok;
      logic [7:0] dat;
   } ptp_frm_t;
endpackage

// file: src/ptp_clock_compare_detect.sv
/*
 Timing-message detection on three ports (rx and tx each), 64-bit time
 clock with addend accumulator, target compare with renewal, two input
 captures and a summary event. Assumes frame bytes arrive on hclk and the
 two capture inputs are asynchronous pins.
*/
// Contract
// - Frame qualifies as timing message by destination address and type byte only.
// - Four fixed multicast addresses ..81 to ..84, each enabled per port.
// - Host-programmed extra address also matches, with its own per-port enable.
// - Control byte at payload offset 32: 0x00 Sync, 0x01 Delay_Req.
// - Payload starts at byte 42 untagged, 46 tagged.
// - Tagged and untagged accepted; only Ethernet II carrying IPv4.
// - 64-bit time readable and writable through upper and lower words.
// - Snapshot command freezes time so both halves read consistently.
// - New time applies only after both halves written, any order.
// - Addend added to accumulator every cycle; overflow increments time.
// - Time continuously compared with 64-bit match time.
// - On equality set timer flag, then renew match time.
// - Renewal bit 1: load match time from next-match pair.
// - Renewal bit 0: add lower next-match word to match time.
// - Time set by host equal to match time also fires.
// - Time and match time wrap through zero.
// - Match and next-match pairs update only after both halves written.
// - Active edge on either capture input snapshots time.
// - Flags for port rx/tx, both captures and match, each enabled.
// - Flags ANDed with enables, ORed into the summary event bit.
// - Capture edge may clear timer flag; input must be active over 40 ns.
// - Slave: rx Sync, tx Delay_Req; master the reverse; mode per port.
// - Capture only after type match and good check sequence; set flag.
`timescale 1ns/10ps
module ptp_clock_compare_detect
   import ptp_pkg::*;
(
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic [31:0]                  hrdata,
   input  wire ptp_pkg::ptp_frm_t [5:0] frm,
   input  wire logic [1:0]              cap_pin,
   output logic                         timing_summary_event,
   output logic                         target_hit
);
   import ptp_pkg::*;

   function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [6:0] i);
      addr_byte = a[8*(5-i[2:0]) +: 8];
   endfunction

   // ==========================================================
   // Host bus
   logic                dp_wr_ff;
   logic [7:0]          dp_addr_ff;
   logic                hreadyout_ff;
   logic [31:0]         hrdata_ff;
   logic [CFG_W-1:0]    cfg_ff;
   logic [FL_W-1:0]     flags_ff;
   logic [FL_W-1:0]     ie_ff;
   logic [31:0]         addend_ff;
   logic [15:0]         xaddr_hi_ff;
   logic [31:0]         xaddr_lo_ff;
   logic [63:0]         time_ff;
   logic [63:0]         snap_ff;
   logic [63:0]         tgt_ff;
   logic [63:0]         rld_ff;
   logic [31:0]         acc_ff;
   logic                chg_ff;
   logic                hit_ff;
   logic                sum_ff;
   logic [63:0]         cap_ff [8];
   logic [31:0]         stg_hi_ff [3];
   logic [31:0]         stg_lo_ff [3];
   logic [1:0]          got_ff [3];

   wire        addr_ph  = hsel & htrans[1] & hready;
   wire        wr       = dp_wr_ff;
   wire [7:0]  wa       = dp_addr_ff;
   wire        cap_rd   = haddr[7:0] >= OFS_CAP_BASE;
   wire [2:0]  cap_idx  = haddr[5:3];
   logic [31:0] rd_val;

   always_comb
   begin
      rd_val = 32'h0;
      if (cap_rd)
         rd_val = haddr[2] ? cap_ff[cap_idx][31:0] : cap_ff[cap_idx][63:32];
      else
         unique case (haddr[7:0])
            OFS_CFG:        rd_val = 32'(cfg_ff);
            OFS_FLAGS:      rd_val = 32'(flags_ff) | (32'(ie_ff) << IE_LSB);
            OFS_SYS:        rd_val = {31'h0, sum_ff};
            OFS_PAIR_HI[0]: rd_val = snap_ff[63:32];
            OFS_PAIR_LO[0]: rd_val = snap_ff[31:0];
            OFS_ADDEND:     rd_val = addend_ff;
            OFS_PAIR_HI[1]: rd_val = tgt_ff[63:32];
            OFS_PAIR_LO[1]: rd_val = tgt_ff[31:0];
            OFS_PAIR_HI[2]: rd_val = rld_ff[63:32];
            OFS_PAIR_LO[2]: rd_val = rld_ff[31:0];
            OFS_XADDR_HI:   rd_val = {16'h0, xaddr_hi_ff};
            OFS_XADDR_LO:   rd_val = xaddr_lo_ff;
            default:        rd_val = 32'h0;
         endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr_ff     <= 1'b0;
         dp_addr_ff   <= 8'h0;
         hrdata_ff    <= 32'h0;
         hreadyout_ff <= 1'b0;
      end
      else
      begin
         hreadyout_ff <= 1'b1;
         dp_wr_ff     <= addr_ph & hwrite;
         if (addr_ph)
            dp_addr_ff <= haddr[7:0];
         if (addr_ph & ~hwrite)
            hrdata_ff <= rd_val;
      end
   end

   assign hreadyout = hreadyout_ff;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;

   // ==========================================================
   // Split 64-bit writes: commit only once both halves are in
   logic [2:0]  commit;
   logic [63:0] pair_val [3];

   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         commit[i]   = wr & (((wa == OFS_PAIR_HI[i]) & got_ff[i][0]) |
                             ((wa == OFS_PAIR_LO[i]) & got_ff[i][1]));
         pair_val[i] = {(wa == OFS_PAIR_HI[i]) ? hwdata : stg_hi_ff[i],
                        (wa == OFS_PAIR_LO[i]) ? hwdata : stg_lo_ff[i]};
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         for (int i = 0; i < 3; i++)
         begin
            stg_hi_ff[i] <= 32'h0;
            stg_lo_ff[i] <= 32'h0;
            got_ff[i]    <= 2'b00;
         end
      else
         for (int i = 0; i < 3; i++)
            if (commit[i])
               got_ff[i] <= 2'b00;
            else if (wr & (wa == OFS_PAIR_HI[i]))
            begin
               stg_hi_ff[i]    <= hwdata;
               got_ff[i][1]    <= 1'b1;
            end
            else if (wr & (wa == OFS_PAIR_LO[i]))
            begin
               stg_lo_ff[i]    <= hwdata;
               got_ff[i][0]    <= 1'b1;
            end
   end

   // ==========================================================
   // Time clock, compare and renewal
   wire [32:0] acc_sum = {1'b0, acc_ff} + {1'b0, addend_ff};
   wire        carry   = acc_sum[32];
   wire        hit     = chg_ff & (time_ff == tgt_ff);
   wire [63:0] tgt_add = tgt_ff + {32'h0, rld_ff[31:0]};

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         acc_ff  <= 32'h0;
         time_ff <= 64'h0;
         chg_ff  <= 1'b0;
         tgt_ff  <= 64'h0;
         rld_ff  <= 64'h0;
         hit_ff  <= 1'b0;
         snap_ff <= 64'h0;
      end
      else
      begin
         acc_ff <= acc_sum[31:0];
         // A host write of the time wins over the increment in that cycle
         if (commit[0])
            time_ff <= pair_val[0];
         else if (carry)
            time_ff <= time_ff + 64'h1;
         chg_ff <= commit[0] | carry;
         hit_ff <= hit;
         if (commit[1])
            tgt_ff <= pair_val[1];
         else if (hit)
            tgt_ff <= cfg_ff[CFG_RELOAD_BIT] ? rld_ff : tgt_add;
         if (commit[2])
            rld_ff <= pair_val[2];
         if (wr & (wa == OFS_CMD) & hwdata[CMD_SNAP_BIT])
            snap_ff <= time_ff;
      end
   end

   assign target_hit = hit_ff;

   // ==========================================================
   // Capture inputs: three-stage sync, then held-active filter
   localparam logic [2:0] GMAX = 3'(GPIO_MIN_CYC);
   logic [1:0] s1_ff, s2_ff, s3_ff;
   logic [2:0] gcnt_ff [2];
   logic [1:0] gev;

   always_comb
      for (int g = 0; g < 2; g++)
         gev[g] = s2_ff[g] & s3_ff[g] & (gcnt_ff[g] == GMAX - 3'd1);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s1_ff      <= 2'b00;
         s2_ff      <= 2'b00;
         s3_ff      <= 2'b00;
         gcnt_ff[0] <= 3'h0;
         gcnt_ff[1] <= 3'h0;
      end
      else
      begin
         s1_ff <= cap_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         for (int g = 0; g < 2; g++)
            if (!(s2_ff[g] & s3_ff[g]))
               gcnt_ff[g] <= 3'h0;
            else if (gcnt_ff[g] != GMAX)
               gcnt_ff[g] <= gcnt_ff[g] + 3'd1;
      end
   end

   // ==========================================================
   // Frame detectors: index d = 2*port + dir (dir 0 rx, 1 tx)
   logic [5:0]  dev;
   logic [63:0] dts [6];
   wire  [47:0] xaddr = {xaddr_hi_ff, xaddr_lo_ff};

   for (genvar d = 0; d < 6; d++)
   begin : g_det
      localparam int P = d / 2;
      logic [6:0]  cnt_ff;
      logic [4:0]  am_ff;
      logic [7:0]  prv_ff;
      logic        tag_ff;
      logic        typ_ff;
      logic        msg_ff;
      logic [63:0] hold_ff;
      logic [4:0]  am_b;
      wire ptp_frm_t f   = frm[d];
      wire [6:0]  bi     = f.sof ? 7'd0 : cnt_ff;
      wire [15:0] pair   = {prv_ff, f.dat};
      wire [6:0]  ctl_at = 7'((tag_ff ? PAY_TAG : PAY_UNTAG) + CTL_OFS);
      wire        mode   = cfg_ff[CFG_MODE_LSB + P];
      wire [7:0]  want   = (mode ^ (d % 2 == 1)) ? MSG_DREQ : MSG_SYNC;
      wire [4:0]  en     = cfg_ff[CFG_EN_LSB + 5*P +: 5];

      always_comb
      begin
         for (int k = 0; k < 4; k++)
            am_b[k] = f.dat == addr_byte(ADDR_FIX0 + 48'(k), bi);
         am_b[4] = f.dat == addr_byte(xaddr, bi);
      end

      // Address, ethertype, control byte and check sequence only; nothing else is checked
      assign dev[d] = f.vld & f.eof & f.fcs_ok & (|(am_ff & en)) & typ_ff & msg_ff;
      assign dts[d] = hold_ff;

      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
         begin
            cnt_ff  <= 7'h0;
            am_ff   <= 5'h0;
            prv_ff  <= 8'h0;
            tag_ff  <= 1'b0;
            typ_ff  <= 1'b0;
            msg_ff  <= 1'b0;
            hold_ff <= 64'h0;
         end
         else if (f.vld)
         begin
            prv_ff <= f.dat;
            cnt_ff <= (bi == 7'h7f) ? bi : 7'(bi + 7'd1);
            if (f.sof)
            begin
               hold_ff <= time_ff;
               am_ff   <= am_b;
               tag_ff  <= 1'b0;
               typ_ff  <= 1'b0;
               msg_ff  <= 1'b0;
            end
            else
            begin
               if (bi < 7'd6)
                  am_ff <= am_ff & am_b;
               if (bi == TYPE_OFS)
               begin
                  tag_ff <= pair == VLAN_TYPE;
                  typ_ff <= pair == IPV4_TYPE;
               end
               if (tag_ff & (bi == TYPE_OFS + VLAN_LEN))
                  typ_ff <= pair == IPV4_TYPE;
               if (bi == ctl_at)
                  msg_ff <= f.dat == want;
            end
         end
      end
   end

   // ==========================================================
   // Flags, enables, captures, configuration
   logic [FL_W-1:0] fl_set, fl_clr, nxt_flags;

   always_comb
   begin
      fl_set = {hit, gev, dev};
      fl_clr = (wr & (wa == OFS_FLAGS)) ? hwdata[FL_W-1:0] : '0;
      if (|(gev & cfg_ff[CFG_GCLR_LSB +: 2]))
         fl_clr[FL_TIMER] = 1'b1;
      // A new event wins over a clear in the same cycle
      nxt_flags = (flags_ff & ~fl_clr) | fl_set;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_ff      <= '0;
         flags_ff    <= '0;
         ie_ff       <= '0;
         addend_ff   <= RST_ADDEND;
         xaddr_hi_ff <= 16'h0;
         xaddr_lo_ff <= 32'h0;
         sum_ff      <= 1'b0;
         for (int i = 0; i < 8; i++)
            cap_ff[i] <= 64'h0;
      end
      else
      begin
         flags_ff <= nxt_flags;
         sum_ff   <= |(nxt_flags & ie_ff);
         for (int i = 0; i < 6; i++)
            if (dev[i])
               cap_ff[i] <= dts[i];
         for (int g = 0; g < 2; g++)
            if (gev[g])
               cap_ff[6+g] <= time_ff;
         if (wr)
            unique case (wa)
               OFS_CFG:      cfg_ff      <= hwdata[CFG_W-1:0];
               OFS_FLAGS:    ie_ff       <= hwdata[IE_LSB +: FL_W];
               OFS_ADDEND:   addend_ff   <= hwdata;
               OFS_XADDR_HI: xaddr_hi_ff <= hwdata[15:0];
               OFS_XADDR_LO: xaddr_lo_ff <= hwdata;
               default:      ;
            endcase
      end
   end

   assign timing_summary_event = sum_ff;
endmodule

// file: bench/ptp_ccd_properties.sv
/*
 Port checker for the timing block, bound to its top module.
 Assumes one slave on the bus, so hready follows hreadyout.
*/
`timescale 1ns/10ps
module ptp_ccd_chk
   import ptp_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        timing_summary_event
);
   logic             wp_ff;
   logic [7:0]       wa_ff;
   logic [CFG_W-1:0] cfg_ff;
   logic [31:0]      add_ff;
   logic [FL_W-1:0]  en_ff;
   wire              take    = hsel & htrans[1] & hready;
   wire              rd_take = take & ~hwrite;
   wire              wr_dat  = wp_ff & hready;
   wire  [7:0]       ofs     = haddr[7:0];

   // ==========================================
   // Shadows of plain fields, taken at the write data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wp_ff  <= 1'b0;
         wa_ff  <= 8'h0;
         cfg_ff <= '0;
         add_ff <= RST_ADDEND;
         en_ff  <= '0;
      end
      else
      begin
         if (hready)
            wp_ff <= take & hwrite;
         if (take)
            wa_ff <= ofs;
         if (wr_dat && wa_ff == OFS_CFG)
            cfg_ff <= hwdata[CFG_W-1:0];
         if (wr_dat && wa_ff == OFS_ADDEND)
            add_ff <= hwdata;
         if (wr_dat && wa_ff == OFS_FLAGS)
            en_ff <= hwdata[IE_LSB +: FL_W];
      end
   end

   // ==========================================
   // Properties
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   a_zero_wait: assert property ($past(hresetn) |-> hreadyout)
      else $error("wait state inserted");
   a_rdata_holds: assert property (!$past(rd_take) |-> $stable(hrdata))
      else $error("read data moved without a read");
   a_hole_zero: assert property (rd_take && ofs inside {8'h34, 8'h38, 8'h3c} |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_cfg_back: assert property (rd_take && ofs == OFS_CFG |=> hrdata == 32'($past(cfg_ff)))
      else $error("config read-back wrong");
   a_addend_back: assert property (rd_take && ofs == OFS_ADDEND |=> hrdata == $past(add_ff))
      else $error("addend read-back wrong");
   a_enable_back: assert property (rd_take && ofs == OFS_FLAGS |=> hrdata[IE_LSB +: FL_W] == $past(en_ff))
      else $error("enable read-back wrong");
   a_sys_level: assert property (rd_take && ofs == OFS_SYS |=> hrdata == {31'h0, $past(timing_summary_event)})
      else $error("summary read differs from pin");
   a_masked_quiet: assert property (en_ff == '0 && $past(en_ff) == '0 |-> !timing_summary_event)
      else $error("summary set with all enables off");
endmodule

bind ptp_clock_compare_detect ptp_ccd_chk u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .timing_summary_event(timing_summary_event));

// file: bench/ptp_frame_src.sv
/*
 Frame source standing in for the switch port paths.
 Assumes one frame at a time; frames come already routed to the port.
*/
`timescale 1ns/10ps
module ptp_frame_src
   import ptp_pkg::*;
(
   input wire logic                hclk,
   output ptp_pkg::ptp_frm_t [5:0] frm
);
   ptp_frm_t q[$];
   int       lane = 0;

   initial
   begin
      frm = '0;
   end

   // Idle lanes flip their byte so a stale value never looks valid
   always @(posedge hclk)
   begin
      for (int i = 0; i < 6; i++)
      begin
         if (q.size() != 0 && i == lane)
            frm[i] <= q[0];
         else
            frm[i] <= '{vld: 1'b0, sof: 1'b0, eof: 1'b0, fcs_ok: 1'b0, dat: ~frm[i].dat};
      end
      if (q.size() != 0)
         void'(q.pop_front());
   end

   // Lookup entry toward the host is assumed in place
   task send(input int k, input logic [47:0] dst, input logic tag, input logic ip,
             input logic [7:0] ctl, input logic fcs);
      int          n;
      int          len;
      int          p;
      int          to;
      logic [15:0] ty;
      logic [7:0]  b;
      p    = tag ? PAY_TAG + CTL_OFS : PAY_UNTAG + CTL_OFS;
      len  = p + 6;
      to   = tag ? 16 : 12;
      ty   = ip ? IPV4_TYPE : 16'h86dd;
      lane = k;
      for (n = 0; n < len; n++)
      begin
         b = 8'(n * 7);
         if (n < 6)
            b = dst[47 - 8*n -: 8];
         if (tag && n == 12)
            b = VLAN_TYPE[15:8];
         if (tag && n == 13)
            b = VLAN_TYPE[7:0];
         if (n == to)
            b = ty[15:8];
         if (n == to + 1)
            b = ty[7:0];
         if (n == p)
            b = ctl;
         q.push_back('{vld: 1'b1, sof: n == 0, eof: n == len - 1, fcs_ok: fcs && n == len - 1, dat: b});
      end
      for (n = 0; n < 200 && q.size() != 0; n++)
         @(posedge hclk);
      @(posedge hclk);
   endtask
endmodule

// file: bench/ptp_clock_compare_detect_tb_top.sv
/*
 Self-checking bench: AHB-Lite host tasks, frame source, model checks.
 Assumes a zero-wait slave whose hreadyout is looped back to hready.
*/
`timescale 1ns/10ps
module ptp_clock_compare_detect_tb_top;
   import ptp_pkg::*;
   logic           hclk, hresetn, hsel, hwrite, hreadyout, hresp, sum_ev, hit, e;
   logic [1:0]     htrans, cap_pin;
   logic [2:0]     hsize;
   logic [31:0]    haddr, hwdata, hrdata, v, cfg;
   logic [8:0]     en, fl;
   logic [7:0]     ctl, want;
   logic [47:0]    dst;
   ptp_frm_t [5:0] frm;
   int             error_cnt = 0;
   int             n_compared = 0;
   int             seed = 32'h2e36819c;
   int             cyc = 0, hit_n = 0, last = 0, gap = 0;
   int             n0, k, sel, i;

   ptp_clock_compare_detect u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frm(frm),
      .cap_pin(cap_pin), .timing_summary_event(sum_ev), .target_hit(hit));
   ptp_frame_src u_src (.hclk(hclk), .frm(frm));

   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (hit === 1'b1)
      begin
         hit_n <= hit_n + 1;
         gap   <= cyc - last;
         last  <= cyc;
      end
   end

   // ==============================================
   // Shared tasks
   task give_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // Ready is sampled at the edge itself, before the slave updates it
   task wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         error_cnt++;
         give_verdict;
      end
   endtask

   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= w;
      wait_rdy;
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      r = hrdata;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(64'(r), 64'(x));
   endtask

   task wp(input int p, input logic [63:0] d);
      wr(OFS_PAIR_LO[p], d[31:0]);
      wr(OFS_PAIR_HI[p], d[63:32]);
   endtask

   // Snapshot first, so both halves come from one instant
   task snap(input logic [63:0] x);
      logic [31:0] hi, lo;
      wr(OFS_CMD, 32'h1);
      xfer(1'b0, OFS_PAIR_HI[0], 32'h0, hi);
      xfer(1'b0, OFS_PAIR_LO[0], 32'h0, lo);
      chk({hi, lo}, x);
   endtask

   task wait_hits(input int n);
      int w;
      for (w = 0; hit_n < n && w < 400; w++)
         @(posedge hclk);
      if (hit_n < n)
      begin
         error_cnt++;
         give_verdict;
      end
   endtask

   // Pin source keeps the level over 40 ns for real events
   task pulse(input int p, input int w);
      cap_pin[p] <= 1'b1;
      repeat (w) @(posedge hclk);
      cap_pin[p] <= 1'b0;
      repeat (10) @(posedge hclk);
   endtask

   initial
   begin
      {hresetn, hsel, hwrite, htrans, cap_pin} = 7'h0;
      hsize  = 3'h2;
      haddr  = 32'h0;
      hwdata = 32'h0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      // ==============================================
      // Reset values, unmapped hole, read-back
      rd(OFS_CFG, 32'h0);
      rd(OFS_FLAGS, 32'h0);
      rd(OFS_ADDEND, RST_ADDEND);
      wr(8'h3c, 32'hffffffff);
      rd(8'h3c, 32'h0);
      v = $random(seed);
      wr(OFS_CFG, v);
      rd(OFS_CFG, v & 32'h1fffff);
      wr(OFS_ADDEND, v);
      rd(OFS_ADDEND, v);
      wr(OFS_ADDEND, 32'h0);
      $display("registers done");
      // ==============================================
      // Split time writes, both orders, time frozen
      // The random addend above may have moved time; restart it from zero
      wp(0, 64'h0);
      wr(OFS_PAIR_LO[0], 32'h89abcdef);
      snap(64'h0);
      wr(OFS_PAIR_HI[0], 32'h01234567);
      snap(64'h0123456789abcdef);
      wr(OFS_PAIR_HI[0], 32'hfedcba98);
      snap(64'h0123456789abcdef);
      wr(OFS_PAIR_LO[0], 32'h76543210);
      snap(64'hfedcba9876543210);
      $display("time access done");
      // ==============================================
      // Compare: reload across the wrap, then add mode, half rate
      wr(OFS_ADDEND, 32'h80000000);
      wr(OFS_CFG, 32'h8);
      wr(OFS_FLAGS, 32'h1 << (IE_LSB + FL_TIMER));
      wp(1, 64'h4);
      wp(2, 64'hc);
      n0 = hit_n;
      wp(0, 64'hfffffffffffffff0);
      wait_hits(n0 + 2);
      chk(64'(gap), 64'h10);
      repeat (60) @(posedge hclk);
      chk(64'(hit_n), 64'(n0 + 2));
      rd(OFS_FLAGS, 32'h01000100);
      rd(OFS_SYS, 32'h1);
      wr(OFS_CFG, 32'h0);
      wp(2, 64'ha);
      wp(1, 64'h3e8);
      n0 = hit_n;
      wp(0, 64'h3d4);
      wait_hits(n0 + 3);
      chk(64'(gap), 64'h14);
      // Time is trimmed by addend only; rewrites happen while idle
      wr(OFS_ADDEND, 32'h0);
      wp(1, 64'h1b58);
      n0 = hit_n;
      wr(OFS_PAIR_LO[0], 32'h1b58);
      repeat (8) @(posedge hclk);
      chk(64'(hit_n), 64'(n0));
      wr(OFS_PAIR_HI[0], 32'h0);
      wait_hits(n0 + 1);
      $display("compare done");
      // ==============================================
      // Frame detection against a model of the qualify rules
      wr(OFS_XADDR_HI, 32'h0a1b);
      wr(OFS_XADDR_LO, 32'h2c3d4e5f);
      for (i = 0; i < 40; i++)
      begin
         v    = $random(seed);
         cfg  = ($random(seed) | (v[7] ? 32'h7fff0 : 32'h0)) & 32'h7fff7;
         en   = 9'($random(seed));
         k    = {$random(seed)} % 6;
         sel  = {$random(seed)} % 6;
         want = (cfg[k / 2] ^ k[0]) ? MSG_DREQ : MSG_SYNC;
         ctl  = v[5] ? want : (v[6] ? 8'h02 : want ^ 8'h01);
         dst  = (sel == 4) ? 48'h0a1b2c3d4e5f : ADDR_FIX0 + 48'(sel);
         e    = sel != 5 && cfg[CFG_EN_LSB + 5 * (k / 2) + sel] && (v[1] | v[2]) && (v[3] | v[4]) && ctl == want;
         fl   = e ? 9'h1 << k : 9'h0;
         wr(OFS_CFG, cfg);
         wr(OFS_FLAGS, {7'h0, en, 16'h1ff});
         u_src.send(k, dst, v[0], v[3] | v[4], ctl, v[1] | v[2]);
         repeat (3) @(posedge hclk);
         rd(OFS_FLAGS, {7'h0, en, 7'h0, fl});
         rd(OFS_SYS, {31'h0, |(fl & en)});
         chk(64'(sum_ev), 64'(|(fl & en)));
         if (e)
            rd(OFS_CAP_BASE + 8'(8 * k) + 8'h4, 32'h1b58);
      end
      $display("frames done");
      // ==============================================
      // Capture pins: short pulse ignored, long one captures and clears
      wr(OFS_CFG, 32'h1 << CFG_GCLR_LSB);
      wr(OFS_FLAGS, 32'h01ff01ff);
      wp(1, 64'h1b58);
      wp(0, 64'h1b58);
      repeat (3) @(posedge hclk);
      rd(OFS_FLAGS, 32'h01ff0100);
      wr(OFS_PAIR_LO[1], 32'h0);
      rd(OFS_PAIR_LO[1], 32'h1b62);
      pulse(0, 3);
      rd(OFS_FLAGS, 32'h01ff0100);
      pulse(0, 6);
      rd(OFS_FLAGS, 32'h01ff0040);
      pulse(1, 6);
      rd(OFS_FLAGS, 32'h01ff00c0);
      rd(OFS_CAP_BASE + 8'h34, 32'h1b58);
      rd(OFS_CAP_BASE + 8'h3c, 32'h1b58);
      rd(OFS_SYS, 32'h1);
      $display("capture pins done");
      give_verdict;
   end
endmodule
